// ===== logic/hims_pkg.sv
package hims_pkg;
  localparam int HIMS_SYS_CLK_MHZ = 250;
  localparam int HIMS_SPI_MAX_MHZ = 30;
  localparam int HIMS_I2C_STD_KHZ = 100;
  localparam int HIMS_I2C_FAST_KHZ = 400;
  localparam int HIMS_DATA_W = 14;
  localparam int HIMS_SHIFT_W = 24;
  localparam int HIMS_BIT_PROT = 11;
  localparam int HIMS_BIT_CLK = 12;
  localparam int HIMS_BIT_DAT = 13;
  localparam logic HIMS_QUEUE_RST = 1'b0;
  typedef enum logic [1:0] {
    HIMS_MODE_PAR = 2'b00,
    HIMS_MODE_SPI = 2'b01,
    HIMS_MODE_I2C = 2'b10
  } hims_mode_e;
endpackage

// ===== logic/hims_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hims_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport owner(output raw, input synced);
  modport sync(input raw, output synced);
endinterface
`default_nettype wire

// ===== logic/hims_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hims_sync (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  hims_sync_if.sync port_if
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= port_if.raw;
      sync_q <= meta_q;
    end
  end
  assign port_if.synced = sync_q;
endmodule
`default_nettype wire

// ===== logic/hims_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] a high queue strap enables the write queue so the host may write at full rate.
// [RL2] the write queue is only offered in parallel mode, never in either serial mode.
// [RL3] the strap is sampled after power-up and after each clear or reset and held until the next.
// [RL4] the host holds the queue strap low in both serial modes; the testbench ties it high in spi mode.
// [RL5] in parallel mode the three shared pins are data bits 11, 12 and 13.
// [RL6] serial kind with protocol select low is spi: bit 12 pin is clock, bit 13 pin is data in.
// [RL7] serial kind with protocol select high is i2c: bit 12 pin is scl, bit 13 pin is sda.
// [RL8] in spi mode bits shift in on the falling serial clock edge, up to 30 mhz.
// [RL9] the host keeps serial data stable at the falling serial clock edge.
// [RL10] i2c clock runs at 100 khz or 400 khz and both are accepted.
// [RL11] sda is only pulled low or released, never driven high.
// [RL12] spi readback bits launch on the rising serial clock edge.
// [RL13] the host changes the mode selects only during reset or power-up; the testbench also changes them with a clear pulse.
module hims_mode_select
  import hims_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic interface_kind_select_in,
  input wire logic queue_strap_in,
  input wire logic [HIMS_BIT_PROT-1:0] par_data_in,
  input wire logic serial_protocol_select_in,
  input wire logic clock_or_bit12_pin_in,
  input wire logic data_in_or_bit13_pin_in,
  input wire logic spi_readback_bit_in,
  input wire logic i2c_sda_pull_low_in,
  output logic [1:0] mode_out,
  output logic queue_enable_out,
  output logic [HIMS_DATA_W-1:0] par_word_out,
  output logic [HIMS_SHIFT_W-1:0] spi_shift_out,
  output logic spi_bit_strobe_out,
  output logic serial_readback_out,
  output logic i2c_scl_out,
  output logic i2c_sda_out,
  output logic sda_out,
  output logic sda_oe_out
);
  hims_sync_if pin_if();
  hims_mode_e mode_q;
  logic [1:0] strap_sync_q;
  logic [1:0] kind_sync_q;
  logic [1:0] prot_sync_q;
  logic clear_q;
  logic sample_q;
  logic queue_q;
  logic sclk_prev_q;
  logic [HIMS_SHIFT_W-1:0] shift_q;
  logic strobe_q;
  logic readback_q;
  logic [HIMS_DATA_W-1:0] par_q;
  logic scl_q;
  logic sda_q;
  logic sda_oe_q;
  logic sclk_now;
  logic sclk_fall;
  logic sclk_rise;
  logic clear_sync_q;
  logic clear_meta_q;
  logic [1:0] boot_q;
  logic [HIMS_BIT_PROT-1:0] par_meta_q;
  logic [HIMS_BIT_PROT-1:0] par_sync_q;

  // fast serial pins share one synchroniser; mode selects are quasi-static
  assign pin_if.raw = {data_in_or_bit13_pin_in, clock_or_bit12_pin_in, serial_protocol_select_in};
  hims_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .port_if(pin_if)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_sync_q <= 2'h0;
      kind_sync_q <= 2'h0;
      prot_sync_q <= 2'h0;
      clear_meta_q <= 1'b0;
      clear_sync_q <= 1'b0;
    end else begin
      strap_sync_q <= {strap_sync_q[0], queue_strap_in};
      kind_sync_q <= {kind_sync_q[0], interface_kind_select_in};
      prot_sync_q <= {prot_sync_q[0], serial_protocol_select_in};
      clear_meta_q <= clear_in;
      clear_sync_q <= clear_meta_q;
    end
  end

  // low data bits take the same two stages as the shared pins so the word stays aligned
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      par_meta_q <= '0;
      par_sync_q <= '0;
    end else begin
      par_meta_q <= par_data_in;
      par_sync_q <= par_meta_q;
    end
  end

  // the post-reset sample waits until the strap synchronisers hold real pin levels
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_q <= 2'h0;
    end else begin
      boot_q <= {boot_q[0], 1'b1};
    end
  end

  // sample request after reset release and on each clear rising edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clear_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      clear_q <= clear_sync_q;
      sample_q <= (boot_q == 2'h1) | (clear_sync_q & ~clear_q); // [RL3]
    end
  end

  // mode captured with the strap so it cannot change mid-operation
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= HIMS_MODE_PAR;
    end else if (sample_q) begin
      if (!kind_sync_q[1]) begin
        mode_q <= HIMS_MODE_PAR; // [RL5]
      end else if (prot_sync_q[1]) begin
        mode_q <= HIMS_MODE_I2C; // [RL7]
      end else begin
        mode_q <= HIMS_MODE_SPI; // [RL6]
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      queue_q <= HIMS_QUEUE_RST;
    end else if (sample_q) begin
      // serial strap ignored even if mis-tied high
      queue_q <= strap_sync_q[1] & ~kind_sync_q[1]; // [RL1] [RL2] [RL3] [RL4]
    end
  end

  assign sclk_now = pin_if.synced[1];
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_now;
    end
  end
  assign sclk_fall = sclk_prev_q & ~sclk_now;
  assign sclk_rise = ~sclk_prev_q & sclk_now;

  // 30 mhz clock gives ~8 system cycles per period, enough for edge finding
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= (mode_q == HIMS_MODE_SPI) && sclk_fall;
      if ((mode_q == HIMS_MODE_SPI) && sclk_fall) begin
        shift_q <= {shift_q[HIMS_SHIFT_W-2:0], pin_if.synced[2]}; // [RL8] [RL9]
      end
    end
  end

  // launched on the rise so the far receiver sees it settled at the next fall
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      readback_q <= 1'b0;
    end else if ((mode_q == HIMS_MODE_SPI) && sclk_rise) begin
      readback_q <= spi_readback_bit_in; // [RL12]
    end
  end

  // parallel word is a plain pin mirror, same settling rules as the bus
  // a word caught mid-change may mix old and new bits; the host's write timing decides validity
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      par_q <= '0;
    end else if (mode_q == HIMS_MODE_PAR) begin
      par_q <= {pin_if.synced, par_sync_q}; // [RL5]
    end
  end

  // i2c pins pass as levels; sampling at 250 mhz covers 100 and 400 khz
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= (mode_q == HIMS_MODE_I2C) ? pin_if.synced[1] : 1'b1; // [RL10]
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_q <= 1'b1;
    end else begin
      sda_q <= (mode_q == HIMS_MODE_I2C) ? pin_if.synced[2] : 1'b1; // [RL10]
    end
  end

  // the released line rises through the board pull-up, so only low is ever driven
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (mode_q == HIMS_MODE_I2C) && i2c_sda_pull_low_in; // [RL11]
    end
  end

  assign mode_out = mode_q;
  assign queue_enable_out = queue_q;
  assign par_word_out = par_q;
  assign spi_shift_out = shift_q;
  assign spi_bit_strobe_out = strobe_q;
  assign serial_readback_out = readback_q;
  assign i2c_scl_out = scl_q;
  assign i2c_sda_out = sda_q;
  assign sda_out = 1'b0; // [RL11]
  assign sda_oe_out = sda_oe_q;
endmodule
`default_nettype wire

// ===== verification/hims_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hims_host_model (
  output logic sclk_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    din_out = 1'b1;
  end
  // data moves mid high phase, settled at each fall
  task automatic spi_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      din_out = w[i];
      #31.25 sclk_out = 1'b0;
      #62.5 sclk_out = 1'b1;
      #31.25;
    end
    din_out = ~w[0];
  endtask
  // sda released to the pull-up while scl runs
  task automatic scl_cycle(input int half_ns);
    din_out = 1'b1;
    sclk_out = 1'b0;
    #(half_ns) sclk_out = 1'b1;
    #(half_ns);
  endtask
endmodule
`default_nettype wire

// ===== verification/hims_mode_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hims_mode_select_assertions
  import hims_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic interface_kind_select_in,
  input wire logic queue_strap_in,
  input wire logic serial_protocol_select_in,
  input wire logic clock_or_bit12_pin_in,
  input wire logic i2c_sda_pull_low_in,
  input wire logic [1:0] mode_out,
  input wire logic queue_enable_out,
  input wire logic spi_bit_strobe_out,
  input wire logic serial_readback_out,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence clr_rise;
    $rose(clear_in);
  endsequence
  sequence sclk_fall;
    mode_out == HIMS_MODE_SPI && $fell(clock_or_bit12_pin_in);
  endsequence
  a_mode_on_clear: assert property (clr_rise |-> ##[3:5] mode_out == (interface_kind_select_in ?
    (serial_protocol_select_in ? HIMS_MODE_I2C : HIMS_MODE_SPI) : HIMS_MODE_PAR)) else $error("mode not latched");
  a_queue_on_clear: assert property (clr_rise |-> ##[3:5]
    queue_enable_out == (queue_strap_in && !interface_kind_select_in)) else $error("queue not latched");
  a_queue_serial_off: assert property (mode_out != HIMS_MODE_PAR |-> !queue_enable_out)
    else $error("queue on in serial");
  a_sda_never_high: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_oe_follows_pull: assert property (mode_out == HIMS_MODE_I2C && $stable(mode_out) |=>
    sda_oe_out == $past(i2c_sda_pull_low_in)) else $error("sda enable wrong");
  a_strobe_one_cycle: assert property (spi_bit_strobe_out |=> !spi_bit_strobe_out) else $error("strobe long");
  a_shift_on_fall: assert property (sclk_fall |-> ##[3:5] spi_bit_strobe_out) else $error("no shift");
  a_readback_hold: assert property (sclk_fall |-> ##2 $stable(serial_readback_out) [*8])
    else $error("readback moved on fall");
  a_mode_after_reset: assert property ($fell(rst_in) |-> ##[2:4] mode_out == (interface_kind_select_in ?
    (serial_protocol_select_in ? HIMS_MODE_I2C : HIMS_MODE_SPI) : HIMS_MODE_PAR)
    && queue_enable_out == (queue_strap_in && !interface_kind_select_in)) else $error("reset sample wrong");
endmodule
bind hims_mode_select hims_mode_select_assertions u_chk (.*);
`default_nettype wire

// ===== verification/hims_mode_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hims_mode_select_tb
  import hims_pkg::*;
;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, clear_in = 1'b0, interface_kind_select_in = 1'b0;
  logic queue_strap_in = 1'b0, serial_protocol_select_in = 1'b0, spi_readback_bit_in = 1'b1;
  logic i2c_sda_pull_low_in = 1'b0, clock_or_bit12_pin_in, din, queue_enable_out, spi_bit_strobe_out;
  logic serial_readback_out, i2c_scl_out, i2c_sda_out, sda_out, sda_oe_out;
  logic [HIMS_BIT_PROT-1:0] par_data_in = '0;
  logic [HIMS_DATA_W-1:0] par_word_out;
  logic [1:0] mode_out;
  logic [HIMS_SHIFT_W-1:0] spi_shift_out;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, strobes = 0;
  // open-drain line with pull-up: low if either side pulls
  wire logic data_in_or_bit13_pin_in = din & ~sda_oe_out;
  hims_host_model host (.sclk_out(clock_or_bit12_pin_in), .din_out(din));
  hims_mode_select DUT (.*);
  initial forever #2 sys_clk_in = ~sys_clk_in;
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  // readback source flips on every bit strobe, as the same-clock logic behind it would
  always @(posedge sys_clk_in) begin
    if (spi_bit_strobe_out === 1'b1) begin
      strobes <= strobes + 1;
      spi_readback_bit_in <= ~spi_readback_bit_in;
    end
  end
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // selects change only around a clear, never mid-traffic
  task automatic setup(input logic k, input logic p, input logic s);
    interface_kind_select_in <= k;
    serial_protocol_select_in <= p;
    queue_strap_in <= s;
    clear_in <= 1'b1;
    tick(3);
    clear_in <= 1'b0;
    tick(8);
    cmp("mode", k ? (p ? HIMS_MODE_I2C : HIMS_MODE_SPI) : HIMS_MODE_PAR, mode_out);
    cmp("queue", s && !k, queue_enable_out);
  endtask
  initial begin
    tick(3);
    rst_in <= 1'b0;
    tick(4);
    setup(1'b0, 1'b0, 1'b1);
    // shared pins idle with clock and data high and protocol select low
    par_data_in <= 11'h255;
    tick(5);
    cmp("par word", 24'h003255, par_word_out);
    queue_strap_in <= 1'b0;
    tick(8);
    cmp("queue held", 24'h1, queue_enable_out);
    setup(1'b1, 1'b0, 1'b1);
    host.spi_word(24'ha5c3e1);
    tick(8);
    cmp("shift", 24'ha5c3e1, spi_shift_out);
    cmp("strobes", 24'h18, strobes[23:0]);
    // 24 flips leave the source high at the last rise; a fall launch would show low
    cmp("readback", 24'h1, serial_readback_out);
    par_data_in <= 11'h234;
    tick(5);
    cmp("par frozen", 24'h003255, par_word_out);
    setup(1'b1, 1'b1, 1'b0);
    fork
      host.scl_cycle(1250);
      begin
        tick(100);
        cmp("scl low", 24'h0, i2c_scl_out);
      end
    join
    host.scl_cycle(5000);
    tick(1);
    cmp("scl high", 24'h1, i2c_scl_out);
    i2c_sda_pull_low_in <= 1'b1;
    tick(6);
    cmp("sda pulled", 24'h0, i2c_sda_out);
    i2c_sda_pull_low_in <= 1'b0;
    tick(6);
    cmp("sda released", 24'h1, i2c_sda_out);
    rst_in <= 1'b1;
    interface_kind_select_in <= 1'b0;
    queue_strap_in <= 1'b1;
    tick(3);
    rst_in <= 1'b0;
    tick(6);
    cmp("mode after reset", HIMS_MODE_PAR, mode_out);
    cmp("queue after reset", 24'h1, queue_enable_out);
    conclude();
  end
endmodule
`default_nettype wire
